// ==== pma_pkg.sv ====
package pma_pkg;

  // array shape defaults
  localparam int NUM_DED = 10;
  localparam int NUM_IO = 8;
  localparam int PT_PER_CELL = 8;

  // register map, byte addresses
  localparam logic [11:0] TERM_BASE = 12'h000;
  localparam logic [11:0] TERM_STRIDE = 12'h008;
  localparam logic [11:0] TERM_HI_OFF = 12'h004;
  localparam logic [11:0] CFG_OFF = 12'h400;
  localparam logic [11:0] CTRL_OFF = 12'h404;
  localparam logic [11:0] STAT_OFF = 12'h408;

  // field positions
  localparam int CFG_BITS_PER_CELL = 4;
  localparam int CTRL_RUN_BIT = 0;
  localparam int STAT_FB_LSB = 0;
  localparam int STAT_OE_LSB = 8;
  localparam int STAT_FF_LSB = 16;

  // reset values: erased array
  localparam logic [63:0] TERM_ERASED = 64'hffff_ffff_ffff_ffff;
  localparam logic [31:0] CFG_ERASED = 32'hcccc_cccc;
  localparam logic CTRL_RUN_RST = 1'b0;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // per-macrocell configuration nibble
  typedef struct packed {
    logic fb_en;
    logic out_en;
    logic registered;
    logic pol_high;
  } pma_mc_cfg_t;

  // pending write held between address and data phases
  typedef struct packed {
    logic aw_full;
    logic [11:0] addr;
    logic w_full;
    logic [31:0] data;
    logic [3:0] strb;
  } pma_wr_hold_t;

  // registered answer of one channel
  typedef struct packed {
    logic valid;
    logic [1:0] resp;
    logic [31:0] data;
  } pma_rsp_t;

endpackage

// ==== pma_macrocell.sv ====
`timescale 1ns/1ps
module pma_macrocell #(
  parameter int PT = 8
) (
  // clock and device-clock enable
  input wire logic clk,
  input wire logic tick,
  // array side
  input wire logic [PT-1:0] terms,
  input wire logic oe_term,
  input wire pma_pkg::pma_mc_cfg_t cfg,
  // pin side
  input wire logic pin_lvl,
  output logic drive,
  output logic drive_en,
  output logic fb,
  output logic ff
);

  logic sum;
  logic xo;
  logic ff_q;
  logic ff_d;

  always_comb begin
    sum = |terms;
    xo = sum ^ ~cfg.pol_high;
    ff_d = tick ? xo : ff_q;
    drive = cfg.registered ? ff_q : xo;
    drive_en = cfg.out_en & oe_term;
    if (!cfg.fb_en) begin
      fb = 1'b0;
    end else if (cfg.registered) begin
      fb = ff_q;
    end else begin
      fb = pin_lvl;
    end
  end

  // no reset, power-up contents undefined
  always_ff @(posedge clk) begin
    ff_q <= ff_d;
  end

  assign ff = ff_q;

endmodule

// ==== pma_top.sv ====
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// Overview of operation
// - eighteen inputs total: ten dedicated pins plus eight shared I/O pins, eight outputs.
// - array literals are true and inverted dedicated inputs and macrocell feedbacks.
// - seventy-two product terms, nine per cell, each ANDing any of 36 literals.
// - each cell ORs its eight product terms, feeding a polarity XOR.
// - programmed polarity cell passes the sum true; erased passes it inverted.
// - registered mode captures the sum on device clock rise; feedback from flop.
// - combinatorial mode outputs the sum directly; feedback taken from the pin level.
// - enable term high drives the pin; low floats it for use as input.
// - eight independent enable terms, one per pin, each freely programmable.
// - registered or combinatorial mode chosen separately per macrocell.
// - combinatorial: high/low output with pin or no feedback, or pure input.
// - registered: high/low output with flop or no feedback, or buried register.
// - erased cell is combinatorial, active low, with pin feedback.
module pma_top #(
  parameter int N_DED = pma_pkg::NUM_DED,
  parameter int N_IO = pma_pkg::NUM_IO,
  parameter int PT = pma_pkg::PT_PER_CELL
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RESET_N,
  // axi4-lite write address
  input wire logic [11:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  // axi4-lite write data
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // axi4-lite write response
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // axi4-lite read address
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  // axi4-lite read data
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // device clock pin
  input wire logic DEV_CLK,
  // dedicated inputs
  input wire logic [N_DED-1:0] DED_IN,
  // shared I/O pins
  input wire logic [N_IO-1:0] IO_IN,
  output logic [N_IO-1:0] IO_OUT,
  output logic [N_IO-1:0] IO_OE_N
);

  localparam int LIT_W = 2 * (N_DED + N_IO);
  localparam int HI_W = LIT_W - 32;
  localparam int N_TERMS = N_IO * (PT + 1);
  localparam int CFG_W = pma_pkg::CFG_BITS_PER_CELL * N_IO;

  if (N_IO < 1 || N_IO > 8 || N_DED < 1 || PT < 1 || LIT_W <= 32 || LIT_W > 64 ||
      N_TERMS * 8 > 1024) begin : g_bad_shape
    $error("pma_top: array shape does not fit the register map");
  end

  // address decode
  function automatic logic is_term(input logic [11:0] a);
    return (a >= pma_pkg::TERM_BASE) && (int'(a - pma_pkg::TERM_BASE) < N_TERMS * 8);
  endfunction

  function automatic int term_idx(input logic [11:0] a);
    return int'((a - pma_pkg::TERM_BASE) / pma_pkg::TERM_STRIDE);
  endfunction

  function automatic logic is_hi(input logic [11:0] a);
    return (a & pma_pkg::TERM_HI_OFF) != 12'h000;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // a product term: every connected literal must be high
  function automatic logic pterm(input logic [LIT_W-1:0] mask, input logic [LIT_W-1:0] lit);
    return &(~mask | lit);
  endfunction

  // ---------------- input synchronisers and device clock enable ----------------
  logic [N_DED-1:0] ded_s1_q, ded_s2_q;
  logic [N_IO-1:0] io_s1_q, io_s2_q;
  logic clk_s1_q, clk_s2_q, clk_s3_q;
  logic run_q;
  logic dev_tick;

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ded_s1_q <= '0;
      ded_s2_q <= '0;
      io_s1_q <= '0;
      io_s2_q <= '0;
      clk_s1_q <= 1'b0;
      clk_s2_q <= 1'b0;
      clk_s3_q <= 1'b0;
    end else begin
      ded_s1_q <= DED_IN;
      ded_s2_q <= ded_s1_q;
      io_s1_q <= IO_IN;
      io_s2_q <= io_s1_q;
      clk_s1_q <= DEV_CLK;
      clk_s2_q <= clk_s1_q;
      clk_s3_q <= clk_s2_q;
    end
  end

  // one shared rising-edge enable for every cell flop
  assign dev_tick = clk_s2_q & ~clk_s3_q & run_q;

  // ---------------- configuration store and bus state ----------------
  logic [LIT_W-1:0] mask_q [N_TERMS];
  logic [LIT_W-1:0] mask_d [N_TERMS];
  logic [CFG_W-1:0] cfg_q, cfg_d;
  logic run_d;
  pma_pkg::pma_wr_hold_t wh_q, wh_d;
  pma_pkg::pma_rsp_t b_q, b_d, r_q, r_d;

  // ---------------- array and macrocells ----------------
  logic [N_IO-1:0] fb_v, drive_v, den_v, ff_v;
  logic [LIT_W-1:0] lit;

  assign lit = {~fb_v, ~ded_s2_q, fb_v, ded_s2_q};

  for (genvar c = 0; c < N_IO; c++) begin : g_cell
    logic [PT-1:0] terms;
    logic oe_term;
    for (genvar p = 0; p < PT; p++) begin : g_pt
      assign terms[p] = pterm(mask_q[c * PT + p], lit);
    end
    // own enable term per pin, placed after all sum terms
    assign oe_term = pterm(mask_q[N_IO * PT + c], lit);
    pma_macrocell #(
      .PT(PT)
    ) u_cell (
      .clk(REF_CLK),
      .tick(dev_tick),
      .terms(terms),
      .oe_term(oe_term),
      .cfg(pma_pkg::pma_mc_cfg_t'(cfg_q[pma_pkg::CFG_BITS_PER_CELL * c +: pma_pkg::CFG_BITS_PER_CELL])),
      .pin_lvl(io_s2_q[c]),
      .drive(drive_v[c]),
      .drive_en(den_v[c]),
      .fb(fb_v[c]),
      .ff(ff_v[c])
    );
  end

  // ---------------- pin drivers ----------------
  logic [N_IO-1:0] io_out_q, io_out_d, io_oe_n_q, io_oe_n_d;

  always_comb begin
    io_out_d = drive_v;
    io_oe_n_d = ~(den_v & {N_IO{run_q}});
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      io_out_q <= '0;
      io_oe_n_q <= '1;
    end else begin
      io_out_q <= io_out_d;
      io_oe_n_q <= io_oe_n_d;
    end
  end

  assign IO_OUT = io_out_q;
  assign IO_OE_N = io_oe_n_q;

  // ---------------- axi4-lite slave ----------------
  logic do_wr;
  logic [31:0] wr_word;
  logic [31:0] stat_word;
  int widx;
  int ridx;

  assign S_AXI_AWREADY = ~wh_q.aw_full;
  assign S_AXI_WREADY = ~wh_q.w_full;
  assign S_AXI_ARREADY = ~r_q.valid;
  assign do_wr = wh_q.aw_full & wh_q.w_full & ~b_q.valid;

  assign stat_word = (32'(fb_v) << pma_pkg::STAT_FB_LSB) | (32'(den_v) << pma_pkg::STAT_OE_LSB) |
                     (32'(ff_v) << pma_pkg::STAT_FF_LSB);

  always_comb begin
    wh_d = wh_q;
    b_d = b_q;
    mask_d = mask_q;
    cfg_d = cfg_q;
    run_d = run_q;
    wr_word = 32'h0000_0000;
    widx = term_idx(wh_q.addr);
    if (S_AXI_AWVALID && !wh_q.aw_full) begin
      wh_d.aw_full = 1'b1;
      wh_d.addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !wh_q.w_full) begin
      wh_d.w_full = 1'b1;
      wh_d.data = S_AXI_WDATA;
      wh_d.strb = S_AXI_WSTRB;
    end
    if (b_q.valid && S_AXI_BREADY) begin
      b_d.valid = 1'b0;
    end
    if (do_wr) begin
      wh_d.aw_full = 1'b0;
      wh_d.w_full = 1'b0;
      b_d.valid = 1'b1;
      b_d.resp = pma_pkg::RESP_OKAY;
      if (wh_q.addr == pma_pkg::CTRL_OFF) begin
        wr_word = merge(32'(run_q) << pma_pkg::CTRL_RUN_BIT, wh_q.data, wh_q.strb);
        run_d = wr_word[pma_pkg::CTRL_RUN_BIT];
      end else if (wh_q.addr == pma_pkg::STAT_OFF) begin
        b_d.resp = pma_pkg::RESP_SLVERR;
      end else if (!is_term(wh_q.addr) && wh_q.addr != pma_pkg::CFG_OFF) begin
        b_d.resp = pma_pkg::RESP_DECERR;
      end else if (run_q) begin
        b_d.resp = pma_pkg::RESP_SLVERR;
      end else if (wh_q.addr == pma_pkg::CFG_OFF) begin
        wr_word = merge(32'(cfg_q), wh_q.data, wh_q.strb);
        cfg_d = wr_word[CFG_W-1:0];
      end else if (is_hi(wh_q.addr)) begin
        wr_word = merge(32'(mask_q[widx][LIT_W-1:32]), wh_q.data, wh_q.strb);
        mask_d[widx][LIT_W-1:32] = wr_word[HI_W-1:0];
      end else begin
        mask_d[widx][31:0] = merge(mask_q[widx][31:0], wh_q.data, wh_q.strb);
      end
    end
  end

  always_comb begin
    r_d = r_q;
    ridx = term_idx(S_AXI_ARADDR);
    if (r_q.valid && S_AXI_RREADY) begin
      r_d.valid = 1'b0;
    end
    if (S_AXI_ARVALID && !r_q.valid) begin
      r_d.valid = 1'b1;
      r_d.resp = pma_pkg::RESP_OKAY;
      r_d.data = 32'h0000_0000;
      if (S_AXI_ARADDR == pma_pkg::CFG_OFF) begin
        r_d.data = 32'(cfg_q);
      end else if (S_AXI_ARADDR == pma_pkg::CTRL_OFF) begin
        r_d.data = 32'(run_q) << pma_pkg::CTRL_RUN_BIT;
      end else if (S_AXI_ARADDR == pma_pkg::STAT_OFF) begin
        r_d.data = stat_word;
      end else if (!is_term(S_AXI_ARADDR)) begin
        r_d.resp = pma_pkg::RESP_DECERR;
      end else if (is_hi(S_AXI_ARADDR)) begin
        r_d.data = 32'(mask_q[ridx][LIT_W-1:32]);
      end else begin
        r_d.data = mask_q[ridx][31:0];
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wh_q <= '0;
      b_q <= '0;
      r_q <= '0;
      run_q <= pma_pkg::CTRL_RUN_RST;
      cfg_q <= pma_pkg::CFG_ERASED[CFG_W-1:0];
      for (int t = 0; t < N_TERMS; t++) begin
        mask_q[t] <= pma_pkg::TERM_ERASED[LIT_W-1:0];
      end
    end else begin
      wh_q <= wh_d;
      b_q <= b_d;
      r_q <= r_d;
      run_q <= run_d;
      cfg_q <= cfg_d;
      mask_q <= mask_d;
    end
  end

  assign S_AXI_BVALID = b_q.valid;
  assign S_AXI_BRESP = b_q.resp;
  assign S_AXI_RVALID = r_q.valid;
  assign S_AXI_RDATA = r_q.data;
  assign S_AXI_RRESP = r_q.resp;

endmodule

// ==== pma_chk.sv ====
`timescale 1ns/1ps
module pma_chk (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RESET_N,
  // write channels
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // read channels
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);
  sequence aw_take;
    S_AXI_AWVALID && S_AXI_AWREADY;
  endsequence
  sequence w_take;
    S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence both_take;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY && !S_AXI_BVALID;
  endsequence
  a_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped early");
  a_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped early");
  a_ar_blocked: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read address taken while data pending");
  a_rd_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read answer late");
  a_aw_busy: assert property (aw_take |=> !S_AXI_AWREADY)
    else $error("second address taken");
  a_w_busy: assert property (w_take |=> !S_AXI_WREADY)
    else $error("second data taken");
  a_wr_answer: assert property (both_take |-> ##[1:2] S_AXI_BVALID)
    else $error("write answer late");
  a_b_clear: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("write response repeated");
  a_resp_legal: assert property (S_AXI_BVALID |-> S_AXI_BRESP != 2'h1)
    else $error("illegal write response");
endmodule

bind pma_top pma_chk pma_chk_inst (.REF_CLK, .RESET_N, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID,
  .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID, .S_AXI_ARREADY,
  .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY);

// ==== pma_board.sv ====
`timescale 1ns/1ps
module pma_board (
  // clock
  input wire logic clk,
  // board wishes
  input wire logic [9:0] ded_val,
  input wire logic [7:0] brd_val,
  input wire logic [7:0] brd_en,
  // device pins
  input wire logic [7:0] io_out,
  input wire logic [7:0] io_oe_n,
  output logic [9:0] ded_in,
  output logic [7:0] io_in
);
  logic [7:0] last_q = 8'h00;
  assign ded_in = ded_val;
  // undriven pins wander instead of keeping the old level
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!io_oe_n[i]) io_in[i] = io_out[i];
      else if (brd_en[i]) io_in[i] = brd_val[i];
      else io_in[i] = ~last_q[i];
    end
  end
  always_ff @(posedge clk) last_q <= io_in;
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, dev_clk = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [9:0] ded_val = 10'h000;
  logic [9:0] ded_in;
  logic [7:0] brd_val = 8'h00, brd_en = 8'h00, io_in, io_out, io_oe_n;
  int error_cnt = 0;
  int checks = 0;
  always #2.5 clk = ~clk;
  pma_top pma_top_inst (.REF_CLK(clk), .RESET_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .DEV_CLK(dev_clk),
    .DED_IN(ded_in), .IO_IN(io_in), .IO_OUT(io_out), .IO_OE_N(io_oe_n));
  pma_board pma_board_inst (.clk(clk), .ded_val(ded_val), .brd_val(brd_val), .brd_en(brd_en),
    .io_out(io_out), .io_oe_n(io_oe_n), .ded_in(ded_in), .io_in(io_in));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
    checks++;
    if ((got & msk) !== (exp & msk)) begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok, w_ok, b_ok;
    logic [1:0] r;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_ok = 1'b0;
    while (!b_ok) begin
      @(negedge clk);
      aw_ok = awready === 1'b1;
      w_ok = wready === 1'b1;
      b_ok = bvalid === 1'b1;
      r = bresp;
      @(posedge clk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk({30'h0, r}, {30'h0, er}, 32'h3);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] er);
    logic ar_ok, ok;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    ok = 1'b0;
    while (!ok) begin
      @(negedge clk);
      ar_ok = arready === 1'b1;
      ok = rvalid === 1'b1;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ar_ok) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    chk(d, e, m);
    chk({30'h0, r}, {30'h0, er}, 32'h3);
  endtask
  task automatic test_done;
    if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    test_done();
  end
  initial begin
    logic [11:0] ta[6];
    logic [31:0] td[6];
    logic b;
    // cell0 sum, cell1 sum, cell3 sum, enables of cells 0, 1, 2
    ta = '{12'h000, 12'h040, 12'h0c0, 12'h200, 12'h208, 12'h210};
    td = '{32'h1, 32'h2, 32'h8, 32'h0, 32'h0, 32'h4};
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rdc(12'h400, 32'hcccc_cccc, 32'hffff_ffff, 2'h0);
    rdc(12'h000, 32'hffff_ffff, 32'hffff_ffff, 2'h0);
    rdc(12'h004, 32'h0000_000f, 32'hffff_ffff, 2'h0);
    rdc(12'h40c, 32'h0, 32'hffff_ffff, 2'h3);
    wr(12'h40c, 32'h0, 2'h3);
    wr(12'h408, 32'h0, 2'h2);
    chk({24'h0, io_oe_n}, 32'hff, 32'hff);
    for (int i = 0; i < 6; i++) begin
      wr(ta[i], td[i], 2'h0);
      wr(ta[i] + 12'h004, 32'h0, 2'h0);
    end
    // byte strobe: only byte 1 of cell0 term1 is cleared, term stays false
    wstrb <= 4'h2;
    wr(12'h008, 32'h0, 2'h0);
    wstrb <= 4'hf;
    rdc(12'h008, 32'hffff_00ff, 32'hffff_ffff, 2'h0);
    wr(12'h400, 32'hcccc_bced, 2'h0);
    wr(12'h404, 32'h1, 2'h0);
    rdc(12'h404, 32'h1, 32'hffff_ffff, 2'h0);
    wr(12'h400, 32'h0, 2'h2);
    rdc(12'h400, 32'hcccc_bced, 32'hffff_ffff, 2'h0);
    for (int k = 0; k < 2; k++) begin
      b = k[0];
      ded_val <= {10{b}};
      brd_en <= b ? 8'h00 : 8'h04;
      repeat (6) @(posedge clk);
      chk({24'h0, io_out}, {30'h0, 1'b1, b}, b ? 32'h3 : 32'h1);
      dev_clk <= 1'b1;
      repeat (6) @(posedge clk);
      dev_clk <= 1'b0;
      chk({24'h0, io_out}, {29'h0, 1'b1, ~b, b}, b ? 32'h7 : 32'h3);
      chk({24'h0, io_oe_n}, {28'h0, 1'b1, ~b, 2'b00}, 32'hf);
      rdc(12'h408, {12'h0, b, 1'b0, ~b, 6'h00, b, 2'h3, 4'h0, b, b, ~b, b}, 32'h000a_0f0f, 2'h0);
    end
    wr(12'h404, 32'h0, 2'h0);
    repeat (6) @(posedge clk);
    chk({24'h0, io_oe_n}, 32'hff, 32'hff);
    test_done();
  end
endmodule
